// ==== logic/pcss_defines.svh ====
`ifndef PCSS_DEFINES_SVH
`define PCSS_DEFINES_SVH

// Register offsets on the plain register port; reads and writes share some offsets
`define PCSS_OFS_DATA      4'h0
`define PCSS_OFS_ERR_FEAT  4'h1
`define PCSS_OFS_TAG_RSN   4'h2
`define PCSS_OFS_DSEL      4'h6
`define PCSS_OFS_STAT_CMD  4'h7
`define PCSS_OFS_CFG       4'h8
`define PCSS_OFS_IDENT0    4'h9

// Command codes
`define PCSS_CMD_PACKET    8'hA0
`define PCSS_CMD_SERVICE   8'hA2
`define PCSS_CMD_RDBUF     8'hE4
`define PCSS_CMD_WRBUF     8'hE8

// Device condition bit positions
`define PCSS_ST_BSY        7
`define PCSS_ST_DRDY       6
`define PCSS_ST_DF         5
`define PCSS_ST_DMRD       5    // Data phase layout; shares bit 5 with DF
`define PCSS_ST_SERV       4
`define PCSS_ST_DRQ        3
`define PCSS_ST_CHK        0

// Transfer reason bit positions
`define PCSS_RS_REL        2
`define PCSS_RS_IO         1
`define PCSS_RS_CD         0

// Other fields
`define PCSS_FEAT_OVL      1
`define PCSS_FEAT_DMA      0
`define PCSS_DSEL_DEV      4
`define PCSS_ERR_ABRT      8'h04
`define PCSS_CFG_OVL_SUP   0
`define PCSS_CFG_QUE_SUP   1
`define PCSS_CFG_REL_EN    2
`define PCSS_CFG_OPT_REL   3
`define PCSS_CFG_RDBUF_SUP 4

// Sizes and reset values
`define PCSS_PKT_CODE      2'b00
`define PCSS_PKT_BYTES     12
`define PCSS_PKT_LAST      9'h00B
`define PCSS_BUF_BYTES     512
`define PCSS_BUF_LAST      9'h1FF
`define PCSS_RST_CFG       5'h1_F
`define PCSS_RST_STATUS    8'h40
`define PCSS_RST_ZERO8     8'h00

`endif

// ==== logic/pcss_pkg.sv ====
package pcss_pkg;

    // Command progress
    typedef enum logic [3:0] {
        PCSS_IDLE,
        PCSS_PKT_RX,
        PCSS_BUSY,
        PCSS_XFER,
        PCSS_RELEASED,
        PCSS_SERVREQ,
        PCSS_DONE,
        PCSS_FAIL,
        PCSS_BUF_IN,
        PCSS_BUF_OUT
    } pcss_state_e;

endpackage

// ==== logic/pcss_sequencer.sv ====
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "pcss_defines.svh"
module pcss_sequencer #(
    parameter logic DEV_ID = 1'b0
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Register port
    input  wire logic [3:0]               addr,
    input  wire logic [7:0]               wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [7:0]               rdata,
    // Command engine side
    input  wire logic                     need_xfer,
    input  wire logic                     data_ready,
    input  wire logic                     xfer_to_host,
    input  wire logic                     xfer_done,
    input  wire logic                     cmd_ok,
    input  wire logic                     cmd_err,
    input  wire logic [3:0]               sense_key,
    input  wire logic                     abort_invalid,
    input  wire logic                     eom,
    input  wire logic                     ili,
    input  wire logic                     dev_fault,
    input  wire logic                     other_queued,
    // Packet and progress
    output logic      [`PCSS_PKT_BYTES*8-1:0] pkt_bytes,
    output logic                          cmd_active,
    output pcss_pkg::pcss_state_e         state_now
);
    import pcss_pkg::*;

    typedef struct packed {
        pcss_state_e                        state;
        logic                               ovl;
        logic                               dma;
        logic [4:0]                         tag;
        logic [7:0]                         dsel;
        logic [4:0]                         cfg;
        logic [7:0]                         errr;
        logic [7:0]                         reason;
        logic [7:0]                         status;
        logic [8:0]                         idx;
        logic                               is_pkt;
        logic                               ok_pend;
        logic                               err_pend;
        logic [7:0]                         err_bits;
        logic                               fault;
        logic                               wbuf_prev;
        logic [7:0]                         rdata;
        logic [`PCSS_PKT_BYTES-1:0][7:0]    pkt;
        logic [`PCSS_BUF_BYTES-1:0][7:0]    buff;
    } pcss_regs_s;

    pcss_regs_s q;
    pcss_regs_s next_q;
    logic       ovl_eff;
    logic       sel;
    logic       cmd_wr;
    logic       data_wr;
    logic       data_rd;
    logic [4:0] tag_out;

    // Decoded strobes and overlap qualifiers
    assign ovl_eff = q.ovl && q.cfg[`PCSS_CFG_OVL_SUP];
    assign sel     = q.dsel[`PCSS_DSEL_DEV] == DEV_ID;
    assign cmd_wr  = wr && addr == `PCSS_OFS_STAT_CMD && sel;
    assign data_wr = wr && addr == `PCSS_OFS_DATA;
    assign data_rd = rd && addr == `PCSS_OFS_DATA;
    assign tag_out = (q.is_pkt && ovl_eff && q.cfg[`PCSS_CFG_QUE_SUP]) ? q.tag : 5'h0_0;

    // Next state of every register
    always_comb begin
        next_q = q;
        next_q.rdata = `PCSS_RST_ZERO8;
        // Register reads, answered in the next cycle only
        if (rd) begin
            unique case (addr)
                `PCSS_OFS_ERR_FEAT: next_q.rdata = q.errr;
                `PCSS_OFS_TAG_RSN:  next_q.rdata = q.reason;
                `PCSS_OFS_DSEL:     next_q.rdata = q.dsel;
                `PCSS_OFS_STAT_CMD: next_q.rdata = q.status;
                `PCSS_OFS_CFG:      next_q.rdata = {3'b000, q.cfg};
                `PCSS_OFS_IDENT0:   next_q.rdata = {6'b00_0000, `PCSS_PKT_CODE};
                default:            next_q.rdata = `PCSS_RST_ZERO8;
            endcase
        end
        // Plain register writes; features take effect at once, also for the command in progress
        if (wr) begin
            unique case (addr)
                `PCSS_OFS_ERR_FEAT: begin
                    next_q.ovl = wdata[`PCSS_FEAT_OVL];
                    next_q.dma = wdata[`PCSS_FEAT_DMA];
                end
                `PCSS_OFS_TAG_RSN:  next_q.tag = wdata[7:3];
                `PCSS_OFS_DSEL:     next_q.dsel = wdata;
                `PCSS_OFS_CFG:      next_q.cfg = wdata[4:0];
                default:            next_q.tag = q.tag;
            endcase
        end
        // Command sequencing
        unique case (q.state)
            PCSS_IDLE, PCSS_DONE, PCSS_FAIL: begin
                if (cmd_wr) begin
                    next_q.idx = 9'h000;
                    next_q.is_pkt = 1'b0;
                    next_q.ok_pend = 1'b0;
                    next_q.err_pend = 1'b0;
                    next_q.wbuf_prev = 1'b0;
                    if (wdata == `PCSS_CMD_PACKET) begin
                        // Taken whatever DRDY shows
                        next_q.is_pkt = 1'b1;
                        next_q.state = PCSS_PKT_RX;
                    end else if (wdata == `PCSS_CMD_WRBUF) begin
                        next_q.state = PCSS_BUF_OUT;
                    end else if (wdata == `PCSS_CMD_RDBUF && q.cfg[`PCSS_CFG_RDBUF_SUP] && q.wbuf_prev) begin
                        next_q.state = PCSS_BUF_IN;
                    end else begin
                        // Unknown code, unsupported read-back or read-back without prior write
                        next_q.errr = `PCSS_ERR_ABRT;
                        next_q.state = PCSS_FAIL;
                    end
                end
            end
            PCSS_PKT_RX: begin
                // Byte 0 of the packet is always the first byte written
                if (data_wr) begin
                    next_q.pkt[q.idx[3:0]] = wdata;
                    next_q.idx = q.idx + 9'h001;
                    if (q.idx == `PCSS_PKT_LAST) begin
                        next_q.state = PCSS_BUSY;
                    end
                end
            end
            PCSS_BUSY: begin
                // Errors are acted on here or on SERVICE in PCSS_SERVREQ, never before the whole packet arrived
                if (q.err_pend) begin
                    next_q.errr = q.err_bits;
                    next_q.err_pend = 1'b0;
                    next_q.state = PCSS_FAIL;
                end else if (q.ok_pend) begin
                    next_q.ok_pend = 1'b0;
                    next_q.state = PCSS_DONE;
                end else if (need_xfer) begin
                    if (ovl_eff && q.cfg[`PCSS_CFG_REL_EN]) begin
                        next_q.state = PCSS_RELEASED;
                    end else if (data_ready) begin
                        next_q.state = PCSS_XFER;
                    end else if (ovl_eff && q.cfg[`PCSS_CFG_OPT_REL]) begin
                        next_q.state = PCSS_RELEASED;
                    end
                end
            end
            PCSS_XFER: begin
                if (xfer_done) begin
                    next_q.state = PCSS_BUSY;
                end
            end
            PCSS_RELEASED: begin
                if (q.err_pend || q.ok_pend || (need_xfer && data_ready)) begin
                    next_q.state = PCSS_SERVREQ;
                end
            end
            PCSS_SERVREQ: begin
                // Present whatever the pending work needs
                if (cmd_wr && wdata == `PCSS_CMD_SERVICE) begin
                    if (q.err_pend) begin
                        next_q.errr = q.err_bits;
                        next_q.err_pend = 1'b0;
                        next_q.state = PCSS_FAIL;
                    end else if (q.ok_pend) begin
                        next_q.ok_pend = 1'b0;
                        next_q.state = PCSS_DONE;
                    end else begin
                        next_q.state = PCSS_XFER;
                    end
                end
            end
            PCSS_BUF_IN: begin
                if (data_rd) begin
                    next_q.rdata = q.buff[q.idx];
                    next_q.idx = q.idx + 9'h001;
                    if (q.idx == `PCSS_BUF_LAST) begin
                        next_q.state = PCSS_DONE;
                    end
                end
            end
            PCSS_BUF_OUT: begin
                if (data_wr) begin
                    next_q.buff[q.idx] = wdata;
                    next_q.idx = q.idx + 9'h001;
                    if (q.idx == `PCSS_BUF_LAST) begin
                        next_q.wbuf_prev = 1'b1;
                        next_q.state = PCSS_DONE;
                    end
                end
            end
        endcase
        // Engine events; set placed after the clears so a same-cycle event survives
        if (q.state != PCSS_IDLE && q.state != PCSS_DONE && q.state != PCSS_FAIL) begin
            if (cmd_ok) begin
                next_q.ok_pend = 1'b1;
            end
            if (cmd_err) begin
                next_q.err_pend = 1'b1;
                next_q.err_bits = {sense_key, 1'b0, abort_invalid, eom, ili};
                next_q.fault = dev_fault;
            end
        end
        // Register images on entry to a phase
        if (next_q.state != q.state) begin
            unique case (next_q.state)
                PCSS_PKT_RX: begin
                    next_q.reason = 8'h01;
                    next_q.status = 8'h08;
                end
                PCSS_BUSY: begin
                    next_q.status = 8'h80;
                end
                PCSS_XFER: begin
                    // DMRD only for an overlapped DMA data phase
                    next_q.reason = {tag_out, 1'b0, xfer_to_host, 1'b0};
                    next_q.status = 8'h08;
                    next_q.status[`PCSS_ST_DMRD] = q.dma && ovl_eff;
                end
                PCSS_RELEASED: begin
                    next_q.reason = {tag_out, 3'b100};
                    next_q.status = 8'h00;
                end
                PCSS_SERVREQ: begin
                    next_q.status[`PCSS_ST_SERV] = 1'b1;
                end
                PCSS_DONE: begin
                    next_q.reason = {tag_out, 3'b011};
                    next_q.status = 8'h40;
                    next_q.errr = `PCSS_RST_ZERO8;
                end
                PCSS_FAIL: begin
                    next_q.reason = {tag_out, 3'b011};
                    next_q.status = 8'h40;
                    next_q.status[`PCSS_ST_DF] = q.is_pkt && q.fault;
                    next_q.status[`PCSS_ST_CHK] = |next_q.errr;
                end
                default: begin
                    next_q.reason = 8'h00;
                    next_q.status = 8'h48;
                end
            endcase
        end else if (q.is_pkt && (q.state == PCSS_RELEASED || q.state == PCSS_DONE || q.state == PCSS_FAIL)) begin
            next_q.status[`PCSS_ST_SERV] = other_queued;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.state <= PCSS_IDLE;
            q.cfg <= `PCSS_RST_CFG;
            q.status <= `PCSS_RST_STATUS;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flip-flops, except cmd_active, which is decoded from the state
    assign rdata      = q.rdata;
    assign pkt_bytes  = q.pkt;
    assign state_now  = q.state;
    assign cmd_active = q.state == PCSS_BUSY || q.state == PCSS_XFER || q.state == PCSS_RELEASED
                        || q.state == PCSS_SERVREQ;

    // Checks on the phases
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_BUSY_AFTER_PKT: assert property (q.state == PCSS_PKT_RX && data_wr && q.idx == `PCSS_PKT_LAST
        |=> q.state == PCSS_BUSY && q.status[`PCSS_ST_BSY] && !q.status[`PCSS_ST_DRQ])
        else $error("busy not shown after last packet byte");
    AST_MANDATORY_REL: assert property (q.state == PCSS_BUSY && !q.err_pend && !q.ok_pend && need_xfer
        && ovl_eff && q.cfg[`PCSS_CFG_REL_EN] |=> q.state == PCSS_RELEASED)
        else $error("mandatory bus release skipped");
    AST_REL_IMAGE: assert property (q.state == PCSS_RELEASED |-> q.reason[2:0] == 3'b100
        && q.status[7:5] == 3'b000 && !q.status[`PCSS_ST_DRQ] && !q.status[`PCSS_ST_CHK])
        else $error("bus release image wrong");
    AST_TAG_BACK: assert property ($rose(q.state == PCSS_DONE) && q.is_pkt && ovl_eff
        && q.cfg[`PCSS_CFG_QUE_SUP] |-> q.reason[7:3] == q.tag)
        else $error("tag not returned");
    AST_SERV_LIVE: assert property (q.is_pkt && q.state == PCSS_RELEASED ##1 q.state == PCSS_RELEASED
        |-> q.status[`PCSS_ST_SERV] == $past(other_queued))
        else $error("service bit not following queue");
    AST_SERV_ONLY: assert property (q.state == PCSS_SERVREQ && $past(q.state) == PCSS_RELEASED
        |-> q.status == ($past(q.status) | 8'h10) && q.reason == $past(q.reason)
        && q.errr == $past(q.errr))
        else $error("service request touched other bits");
    AST_SERVICE_GO: assert property (q.state == PCSS_SERVREQ && cmd_wr && wdata == `PCSS_CMD_SERVICE
        |=> q.state inside {PCSS_XFER, PCSS_DONE, PCSS_FAIL})
        else $error("service command ignored");
    AST_DONE_IMAGE: assert property (q.state == PCSS_DONE |-> q.reason[2:0] == 3'b011
        && q.status[7:6] == 2'b01 && !q.status[`PCSS_ST_DRQ] && !q.status[`PCSS_ST_CHK])
        else $error("completion image wrong");
    AST_NO_EARLY_ERR: assert property (q.state == PCSS_PKT_RX |=> q.state != PCSS_FAIL)
        else $error("error ending before packet complete");
    AST_FAIL_IMAGE: assert property (q.state == PCSS_FAIL |-> q.reason[2:0] == 3'b011
        && q.status[7:6] == 2'b01 && !q.status[`PCSS_ST_DRQ] && q.status[`PCSS_ST_CHK] == (|q.errr))
        else $error("error image wrong");
    AST_RDBUF_ABORT: assert property (q.state inside {PCSS_IDLE, PCSS_DONE, PCSS_FAIL} && cmd_wr
        && wdata == `PCSS_CMD_RDBUF
        && !q.cfg[`PCSS_CFG_RDBUF_SUP] |=> q.errr == `PCSS_ERR_ABRT && q.status[`PCSS_ST_CHK])
        else $error("unsupported read-back not aborted");

    COV_RELEASE: cover property (q.state == PCSS_RELEASED ##1 q.state == PCSS_SERVREQ);
    COV_SERVICE: cover property (q.state == PCSS_SERVREQ ##1 q.state == PCSS_XFER);
    COV_RDBUF:   cover property (q.state == PCSS_BUF_IN ##1 q.state == PCSS_DONE);
    COV_PKT_ERR: cover property (q.state == PCSS_BUSY ##1 q.state == PCSS_FAIL);
endmodule

// ==== verif/pcss_host_model.sv ====
`timescale 1ns/100ps
// Host controller on the far side of the register port
module pcss_host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output logic      [3:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd,
    input  wire logic [7:0] rdata
);
    // Quiet bus from time zero
    initial begin
        addr  = 4'h0;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // Write: one strobe cycle; the leading edge wait keeps strobes from merging
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read: data taken in the single cycle it stands
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
endmodule

// ==== verif/test_packet_command_status_sequencer.sv ====
`timescale 1ns/100ps
`include "pcss_defines.svh"
module test_packet_command_status_sequencer;
    import pcss_pkg::*;
    logic clk = 1'b0, reset = 1'b1;
    logic need_xfer, data_ready, xfer_to_host, xfer_done, cmd_ok, cmd_err;
    logic abort_invalid, eom, ili, dev_fault, other_queued, wr, rd, cmd_active;
    logic [3:0] addr, sense_key;
    logic [7:0] wdata, rdata, v, e;
    logic [4:0] tag;
    logic [95:0] pkt_bytes, pe;
    pcss_state_e state_now;
    logic [7:0] bq[$];
    int n_fail = 0, checks = 0;
    int unsigned seed = 10;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    pcss_sequencer dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .need_xfer(need_xfer), .data_ready(data_ready), .xfer_to_host(xfer_to_host),
        .xfer_done(xfer_done), .cmd_ok(cmd_ok), .cmd_err(cmd_err), .sense_key(sense_key),
        .abort_invalid(abort_invalid), .eom(eom), .ili(ili), .dev_fault(dev_fault),
        .other_queued(other_queued), .pkt_bytes(pkt_bytes), .cmd_active(cmd_active),
        .state_now(state_now));
    pcss_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    // Xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
            n_fail++;
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string m);
        host.get(a, v);
        chk(v, exp, m);
    endtask

    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Bounded wait for a state; a stuck design ends the run
    task automatic wait_st(input pcss_state_e s);
        for (int i = 0; i < 300 && state_now !== s; i++) begin
            @(posedge clk);
            #1;
        end
        chk({4'h0, state_now}, {4'h0, s}, "state wait");
        if (state_now !== s)
            close_out();
    endtask

    // Engine pulse: 0 ok, 1 error, 2 transfer end
    task automatic fire(input int w);
        @(posedge clk);
        cmd_ok    <= (w == 0);
        cmd_err   <= (w == 1);
        xfer_done <= (w == 2);
        @(posedge clk);
        {cmd_ok, cmd_err, xfer_done} <= 3'b000;
    endtask

    // Packet command with 12 random bytes; early=1 raises an error mid-packet; DMA follows tag bit 0
    task automatic start_pkt(input logic [4:0] t, input bit early);
        host.put(4'h1, {6'h00, 1'b1, t[0]});
        host.put(4'h2, {t, 3'b000});
        host.put(4'h6, 8'h00);
        host.put(4'h7, `PCSS_CMD_PACKET);
        wait_st(PCSS_PKT_RX);
        for (int i = 0; i < `PCSS_PKT_BYTES; i++) begin
            pe[i*8+:8] = 8'(rnd());
            host.put(4'h0, pe[i*8+:8]);
            if (early && i == 6) begin
                fire(1);
                #1 chk({4'h0, state_now}, {4'h0, PCSS_PKT_RX}, "early error");
            end
        end
        #1 chk({4'h0, state_now}, {4'h0, PCSS_BUSY}, "busy after packet");
        chk({7'h0, pkt_bytes === pe}, 8'h01, "packet bytes");
    endtask

    initial begin
        {need_xfer, data_ready, xfer_to_host, xfer_done, cmd_ok, cmd_err} = 6'h00;
        {abort_invalid, eom, ili, dev_fault, other_queued} = 5'h00;
        sense_key = 4'h0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        // Reset values and an unmapped read
        rchk(4'h7, 8'h40, "status reset");
        rchk(4'h8, 8'h1F, "cfg reset");
        rchk(4'h1, 8'h00, "error reset");
        rchk(4'h3, 8'h00, "unmapped");
        host.get(4'h9, v);
        chk({6'h0, v[1:0]}, {6'h0, `PCSS_PKT_CODE}, "packet size code");
        $display("test reset done");
        // Mandatory release, service request, SERVICE, completion
        need_xfer <= 1'b1;
        tag = 5'(rnd());
        start_pkt(tag, 0);
        wait_st(PCSS_RELEASED);
        chk({7'h0, cmd_active}, 8'h01, "active in release");
        rchk(4'h2, {tag, 3'b100}, "release reason");
        rchk(4'h7, 8'h00, "release status");
        other_queued <= 1'b1;
        rchk(4'h7, 8'h10, "queued in release");
        other_queued <= 1'b0;
        fire(0);
        wait_st(PCSS_SERVREQ);
        rchk(4'h7, 8'h10, "service request");
        rchk(4'h2, {tag, 3'b100}, "reason kept");
        host.put(4'h7, `PCSS_CMD_SERVICE);
        wait_st(PCSS_DONE);
        chk({7'h0, cmd_active}, 8'h00, "inactive when done");
        rchk(4'h7, 8'h40, "done status");
        rchk(4'h2, {tag, 3'b011}, "done reason");
        other_queued <= 1'b1;
        rchk(4'h7, 8'h50, "queued work");
        other_queued <= 1'b0;
        $display("test release done");
        // Release interrupt off, data ready: transfer at once
        host.put(4'h8, 8'h13);
        data_ready   <= 1'b1;
        xfer_to_host <= 1'b1;
        tag = 5'(rnd());
        start_pkt(tag, 0);
        wait_st(PCSS_XFER);
        rchk(4'h2, {tag, 3'b010}, "transfer reason");
        rchk(4'h7, {2'b00, tag[0], 5'h08}, "transfer status");
        fire(0);
        fire(2);
        wait_st(PCSS_DONE);
        rchk(4'h7, 8'h40, "done status");
        $display("test immediate transfer done");
        // Optional release while data is not ready, then SERVICE starts the transfer
        host.put(4'h8, 8'h1B);
        data_ready <= 1'b0;
        tag = 5'(rnd());
        start_pkt(tag, 0);
        wait_st(PCSS_RELEASED);
        data_ready <= 1'b1;
        wait_st(PCSS_SERVREQ);
        rchk(4'h7, 8'h10, "ready to serve");
        host.put(4'h7, `PCSS_CMD_SERVICE);
        wait_st(PCSS_XFER);
        rchk(4'h2, {tag, 3'b010}, "serviced reason");
        fire(0);
        fire(2);
        wait_st(PCSS_DONE);
        $display("test optional release done");
        // Error endings with random sense data
        need_xfer <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            tag = 5'(rnd());
            v = 8'(rnd());
            {sense_key, abort_invalid, eom, ili, dev_fault} <= v;
            e = {v[7:4], 1'b0, v[3:1]};
            start_pkt(tag, k[0]);
            fire(1);
            wait_st(PCSS_FAIL);
            rchk(4'h1, e, "error report");
            rchk(4'h7, {2'b01, dev_fault, 4'h0, e != 8'h00}, "error status");
            rchk(4'h2, {tag, 3'b011}, "error reason");
        end
        $display("test error endings done");
        // Buffer write then read-back of the same 512 bytes
        host.put(4'h7, `PCSS_CMD_WRBUF);
        wait_st(PCSS_BUF_OUT);
        for (int i = 0; i < `PCSS_BUF_BYTES; i++) begin
            bq.push_back(8'(rnd()));
            host.put(4'h0, bq[$]);
        end
        wait_st(PCSS_DONE);
        host.put(4'h7, `PCSS_CMD_RDBUF);
        wait_st(PCSS_BUF_IN);
        for (int i = 0; i < `PCSS_BUF_BYTES; i++)
            rchk(4'h0, bq.pop_front(), "buffer byte");
        wait_st(PCSS_DONE);
        rchk(4'h7, 8'h40, "read-back status");
        $display("test buffer done");
        // Read-back without a buffer write, and an unknown code, abort
        for (int k = 0; k < 2; k++) begin
            host.put(4'h7, k ? 8'h55 : `PCSS_CMD_RDBUF);
            wait_st(PCSS_FAIL);
            rchk(4'h1, `PCSS_ERR_ABRT, "abort code");
            rchk(4'h7, 8'h41, "abort status");
        end
        // Supported bit cleared: read-back aborts even straight after a buffer write
        host.put(4'h8, 8'h0B);
        host.put(4'h7, `PCSS_CMD_WRBUF);
        for (int i = 0; i < `PCSS_BUF_BYTES; i++)
            host.put(4'h0, 8'(rnd()));
        wait_st(PCSS_DONE);
        host.put(4'h7, `PCSS_CMD_RDBUF);
        wait_st(PCSS_FAIL);
        rchk(4'h1, `PCSS_ERR_ABRT, "unsupported abort");
        rchk(4'h7, 8'h41, "unsupported status");
        // Other device selected: command ignored
        host.put(4'h6, 8'h10);
        host.put(4'h7, `PCSS_CMD_PACKET);
        #1 chk({4'h0, state_now}, {4'h0, PCSS_FAIL}, "deselected");
        $display("test aborts done");
        close_out();
    end
endmodule
